// ### hdl/fmc_core_end.sv
// fmc_core_end: core-side end; turns user requests into bus cycles
// assumes: user holds requests until ack; stall from controller
`timescale 1ns/1ps
`default_nettype none
module fmc_core_end
   import fmc_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   fmc_if.core bus,
   input wire logic user_wr,
   input wire logic user_rd,
   input wire logic [7:0] user_addr,
   input wire logic [7:0] user_wdata,
   output logic user_ack,
   output logic [7:0] user_rdata,
   output logic user_busy,
   output logic irq_taken
);
   logic rd_pend;
   logic req_seen;
   // -------------------------------------------------
   // bus master, one strobe per accepted request
   // -------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bus.addr <= FMC_RST_ZERO;
         bus.wdata <= FMC_RST_ZERO;
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
         req_seen <= 1'b0;
      end else begin
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
         if (!bus.stall && !req_seen && !rd_pend && (user_wr || user_rd)) begin
            bus.addr <= user_addr;
            bus.wdata <= user_wdata;
            bus.wr <= user_wr;
            bus.rd <= user_rd & ~user_wr;
            req_seen <= 1'b1;
         end else if (!(user_wr || user_rd)) begin
            req_seen <= 1'b0;
         end
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rd_pend <= 1'b0;
         user_rdata <= FMC_RST_ZERO;
         user_ack <= 1'b0;
      end else begin
         rd_pend <= bus.rd;
         user_ack <= bus.wr | rd_pend;
         if (rd_pend) begin
            user_rdata <= bus.rdata;
         end
      end
   end
   // interrupts deferred while the flash operation runs
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         user_busy <= 1'b0;
         irq_taken <= 1'b0;
      end else begin
         user_busy <= bus.stall;
         irq_taken <= ~bus.stall;
      end
   end
endmodule : fmc_core_end
`default_nettype wire

// ### hdl/fmc_ctrl.sv
// fmc_ctrl: flash controller with key, protection and command sequencer
// assumes: core bus from fmc_if; array modelled as on-chip byte memory
// Contract
// - 32 pages of 512 bytes, page erase
// - write/erase guards in four page-31 bytes
// - read guard byte, one bit per four pages
// - last six bytes of page 31 reserved
// - firmware protecting code must guard last page
// - data register plus high/low pointer bytes
// - access key 0x3b required before command
// - access key cleared after each operation
// - core stalled until operation finishes
// - interrupts held until operation finishes
// - peripherals keep running during stall
// - command 1 programs addressed byte
// - command 2 erases whole addressed page
// - command 3 erases whole array
// - command 4 reads byte into data
// - command 5 erases page then programs
// - guard changes need stored protection key
// - stored key 0xff skips comparison
// - command 8 stores protection key once
// - erased reads 0xff, program clears bits
// - guard bit cleared protects its page
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module fmc_ctrl
   import fmc_pkg::*;
#(
   parameter int unsigned PAGES = FMC_PAGES,
   parameter int unsigned PAGE_BYTES = FMC_PAGE_BYTES
)(
   input wire logic clock,
   input wire logic nrst,
   fmc_if.ctrl bus,
   output logic busy,
   output logic [7:0] last_cmd
);
   localparam int unsigned DEPTH = PAGES * PAGE_BYTES;
   logic [7:0] mem [0:DEPTH-1];
   logic [7:0] key;
   logic [7:0] pkey;
   logic [7:0] data;
   logic [7:0] weg0;
   logic [7:0] weg1;
   logic [7:0] rdg;
   logic [7:0] ptrl;
   logic [7:0] ptrh;
   fmc_state_e state;
   logic [FMC_AW-1:0] cnt;
   logic [FMC_AW-1:0] addr;
   logic [FMC_PAGE_W-1:0] page;
   logic [31:0] we_map;
   logic cmd_wr;
   logic key_ok;
   logic pkey_ok;
   logic we_ok;
   logic rd_ok;
   logic erase_all;
   logic do_prog;
   logic code_ok;
   assign addr = {ptrh[FMC_AW-9:0], ptrl};
   assign page = addr[FMC_AW-1:FMC_PAGE_LSB];
   assign cmd_wr = bus.wr && (bus.addr == FMC_A_CMD) && (state == FMC_ST_IDLE);
   assign key_ok = (key == FMC_ACCESS_KEY);
   // unknown codes neither stall nor update the command register
   assign code_ok = bus.wdata inside {FMC_CMD_WRITE, FMC_CMD_ERASE_PAGE, FMC_CMD_ERASE_ALL,
                                      FMC_CMD_READ, FMC_CMD_ERASE_WRITE, FMC_CMD_PROTECT};
   // -------------------------------------------------
   // protection view from page 31
   // -------------------------------------------------
   assign we_map = {mem[FMC_PROT_WE3_ADDR], mem[FMC_PROT_WE2_ADDR],
                    mem[FMC_PROT_WE1_ADDR], mem[FMC_PROT_WE0_ADDR]};
   assign we_ok = we_map[page];
   assign rd_ok = mem[FMC_PROT_RD_ADDR][page[FMC_PAGE_W-1:2]];
   assign pkey_ok = (mem[FMC_PROT_KEY_ADDR] == FMC_ERASED) ||
                    (mem[FMC_PROT_KEY_ADDR] == pkey);
   // -------------------------------------------------
   // sequencer
   // -------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state <= FMC_ST_IDLE;
         cnt <= '0;
         erase_all <= 1'b0;
         do_prog <= 1'b0;
         last_cmd <= FMC_RST_ZERO;
      end else begin
         case (state)
            FMC_ST_IDLE: begin
               if (cmd_wr && key_ok && code_ok) begin
                  last_cmd <= bus.wdata;
                  case (bus.wdata)
                     FMC_CMD_WRITE: begin
                        state <= we_ok ? FMC_ST_PROG : FMC_ST_DONE;
                     end
                     FMC_CMD_ERASE_PAGE, FMC_CMD_ERASE_WRITE: begin
                        cnt <= {page, {FMC_PAGE_LSB{1'b0}}};
                        erase_all <= 1'b0;
                        do_prog <= (bus.wdata == FMC_CMD_ERASE_WRITE);
                        state <= we_ok ? FMC_ST_ERASE : FMC_ST_DONE;
                     end
                     FMC_CMD_ERASE_ALL: begin
                        cnt <= '0;
                        erase_all <= 1'b1;
                        do_prog <= 1'b0;
                        state <= FMC_ST_ERASE;
                     end
                     FMC_CMD_READ: begin
                        state <= FMC_ST_DONE;
                     end
                     FMC_CMD_PROTECT: begin
                        state <= FMC_ST_PROT;
                     end
                     default: begin
                        state <= FMC_ST_IDLE;
                     end
                  endcase
               end
            end
            FMC_ST_ERASE: begin
               cnt <= cnt + 1'b1;
               if (erase_all ? (cnt == FMC_AW'(DEPTH - 1))
                             : (cnt[FMC_PAGE_LSB-1:0] == '1)) begin
                  state <= do_prog ? FMC_ST_PROG : FMC_ST_DONE;
               end
            end
            FMC_ST_PROG, FMC_ST_PROT: begin
               state <= FMC_ST_DONE;
            end
            FMC_ST_DONE: begin
               state <= FMC_ST_IDLE;
            end
            default: begin
               state <= FMC_ST_IDLE;
            end
         endcase
      end
   end
   // array; erase sets ones, program only clears bits
   always_ff @(posedge clock) begin
      if (state == FMC_ST_ERASE) begin
         mem[cnt] <= FMC_ERASED;
      end else if (state == FMC_ST_PROG) begin
         mem[addr] <= mem[addr] & data;
      end else if (state == FMC_ST_PROT) begin
         if (mem[FMC_PROT_KEY_ADDR] == FMC_ERASED) begin
            mem[FMC_PROT_KEY_ADDR] <= pkey;
         end
         if (pkey_ok) begin
            mem[FMC_PROT_WE0_ADDR] <= mem[FMC_PROT_WE0_ADDR] & weg0;
            mem[FMC_PROT_WE1_ADDR] <= mem[FMC_PROT_WE1_ADDR] & weg1;
            mem[FMC_PROT_WE2_ADDR] <= mem[FMC_PROT_WE2_ADDR] & ptrl;
            mem[FMC_PROT_WE3_ADDR] <= mem[FMC_PROT_WE3_ADDR] & ptrh;
            mem[FMC_PROT_RD_ADDR] <= mem[FMC_PROT_RD_ADDR] & rdg;
         end
      end
   end
   // -------------------------------------------------
   // registers
   // -------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         key <= FMC_RST_ONES;
      end else if (state == FMC_ST_DONE) begin
         key <= FMC_RST_ONES;
      end else if (bus.wr && bus.addr == FMC_A_KEY) begin
         key <= bus.wdata;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         data <= FMC_RST_ZERO;
      end else if (state == FMC_ST_DONE && last_cmd == FMC_CMD_READ && rd_ok) begin
         data <= mem[addr];
      end else if (bus.wr && bus.addr == FMC_A_DATA) begin
         data <= bus.wdata;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pkey <= FMC_RST_ONES;
         weg0 <= FMC_RST_ONES;
         weg1 <= FMC_RST_ONES;
         rdg <= FMC_RST_ONES;
         ptrl <= FMC_RST_ZERO;
         ptrh <= FMC_RST_ZERO;
      end else if (bus.wr) begin
         case (bus.addr)
            FMC_A_PKEY: pkey <= bus.wdata;
            FMC_A_WEG0: weg0 <= bus.wdata;
            FMC_A_WEG1: weg1 <= bus.wdata;
            FMC_A_RDG: rdg <= bus.wdata;
            FMC_A_PTRL: ptrl <= bus.wdata;
            FMC_A_PTRH: ptrh <= bus.wdata;
            default: ;
         endcase
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bus.rdata <= FMC_RST_ZERO;
      end else if (bus.rd) begin
         case (bus.addr)
            FMC_A_CMD: bus.rdata <= last_cmd;
            FMC_A_KEY: bus.rdata <= key;
            FMC_A_PKEY: bus.rdata <= pkey;
            FMC_A_DATA: bus.rdata <= data;
            FMC_A_WEG0: bus.rdata <= weg0;
            FMC_A_WEG1: bus.rdata <= weg1;
            FMC_A_RDG: bus.rdata <= rdg;
            FMC_A_PTRL: bus.rdata <= ptrl;
            FMC_A_PTRH: bus.rdata <= ptrh;
            default: bus.rdata <= FMC_RST_ZERO;
         endcase
      end
   end
   // stall only the core; other logic on clock keeps running
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bus.stall <= 1'b0;
         busy <= 1'b0;
      end else begin
         bus.stall <= (cmd_wr && key_ok && code_ok) ||
                      (state != FMC_ST_IDLE && state != FMC_ST_DONE);
         busy <= (cmd_wr && key_ok && code_ok) ||
                 (state != FMC_ST_IDLE && state != FMC_ST_DONE);
      end
   end
endmodule : fmc_ctrl
`default_nettype wire

// ### inc/fmc_if.sv
// fmc_if: special function register bus between core and flash controller
// assumes: both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface fmc_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic stall;
   modport ctrl (input addr, input wdata, input wr, input rd, output rdata, output stall);
   modport core (output addr, output wdata, output wr, output rd, input rdata, input stall);
endinterface : fmc_if
`default_nettype wire

// ### inc/fmc_pkg.sv
// fmc_pkg: shared constants for the flash controller and its core-side end
// assumes: one 100 MHz clock, byte-wide special function register bus
package fmc_pkg;
   localparam int unsigned FMC_PAGES = 32;
   localparam int unsigned FMC_PAGE_BYTES = 512;
   localparam int unsigned FMC_AW = 14;
   localparam int unsigned FMC_BYTES = FMC_PAGES * FMC_PAGE_BYTES;
   localparam int unsigned FMC_PAGE_LSB = 9;
   localparam int unsigned FMC_PAGE_W = 5;
   // -------------------------------------------------
   // register offsets on the core bus
   // -------------------------------------------------
   localparam logic [7:0] FMC_A_CMD = 8'hb9;
   localparam logic [7:0] FMC_A_KEY = 8'hba;
   localparam logic [7:0] FMC_A_PKEY = 8'hbb;
   localparam logic [7:0] FMC_A_DATA = 8'hbc;
   localparam logic [7:0] FMC_A_WEG0 = 8'hbd;
   localparam logic [7:0] FMC_A_WEG1 = 8'hbe;
   localparam logic [7:0] FMC_A_RDG = 8'hbf;
   localparam logic [7:0] FMC_A_PTRL = 8'hc6;
   localparam logic [7:0] FMC_A_PTRH = 8'hc7;
   // -------------------------------------------------
   // reset values and keys
   // -------------------------------------------------
   localparam logic [7:0] FMC_RST_ZERO = 8'h00;
   localparam logic [7:0] FMC_RST_ONES = 8'hff;
   localparam logic [7:0] FMC_ACCESS_KEY = 8'h3b;
   localparam logic [7:0] FMC_ERASED = 8'hff;
   // protection bytes: last six of page 31
   localparam logic [13:0] FMC_PROT_KEY_ADDR = 14'h3ffa;
   localparam logic [13:0] FMC_PROT_WE0_ADDR = 14'h3ffb;
   localparam logic [13:0] FMC_PROT_WE1_ADDR = 14'h3ffc;
   localparam logic [13:0] FMC_PROT_WE2_ADDR = 14'h3ffd;
   localparam logic [13:0] FMC_PROT_WE3_ADDR = 14'h3ffe;
   localparam logic [13:0] FMC_PROT_RD_ADDR = 14'h3fff;
   // -------------------------------------------------
   // commands
   // -------------------------------------------------
   typedef enum logic [7:0] {
      FMC_CMD_WRITE = 8'h01,
      FMC_CMD_ERASE_PAGE = 8'h02,
      FMC_CMD_ERASE_ALL = 8'h03,
      FMC_CMD_READ = 8'h04,
      FMC_CMD_ERASE_WRITE = 8'h05,
      FMC_CMD_PROTECT = 8'h08
   } fmc_cmd_e;
   typedef enum logic [2:0] {
      FMC_ST_IDLE = 3'b000,
      FMC_ST_ERASE = 3'b001,
      FMC_ST_PROG = 3'b010,
      FMC_ST_PROT = 3'b011,
      FMC_ST_DONE = 3'b100
   } fmc_state_e;
endpackage : fmc_pkg

// ### verif/fmc_properties.sv
// fmc_properties: bus timing checks between core end and controller
// assumes: instantiated beside fmc_if, one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module fmc_properties
   import fmc_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic stall
);
   localparam int MASS_MAX = 16390;
   logic key_ok;
   logic [7:0] op;
   logic [15:0] run_cnt;
   logic code_ok;
   assign code_ok = wdata inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08};
   // -------------------------------------------------
   // helper state: key seen, last code, stall length
   // -------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         key_ok <= 1'b0;
      end else if (wr && addr == FMC_A_KEY) begin
         key_ok <= (wdata == FMC_ACCESS_KEY);
      end else if (stall) begin
         key_ok <= 1'b0;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         op <= 8'h00;
      end else if (wr && addr == FMC_A_CMD) begin
         op <= wdata;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         run_cnt <= 16'h0000;
      end else begin
         run_cnt <= stall ? run_cnt + 16'h0001 : 16'h0000;
      end
   end
   // -------------------------------------------------
   // properties
   // -------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence s_cmd_wr;
      wr && addr == FMC_A_CMD && !stall;
   endsequence
   sequence s_op_start;
      $rose(stall);
   endsequence
   property p_cmd_runs;
      s_cmd_wr ##0 (key_ok && code_ok) |=> stall;
   endproperty
   property p_no_key;
      s_cmd_wr ##0 !key_ok |=> !stall;
   endproperty
   property p_bad_code;
      s_cmd_wr ##0 !code_ok |=> !stall;
   endproperty
   property p_from_cmd;
      s_op_start |-> $past(wr) && $past(addr) == FMC_A_CMD;
   endproperty
   property p_short;
      s_op_start ##0 (op == 8'h01 || op == 8'h04 || op == 8'h08) |-> ##[1:3] !stall;
   endproperty
   property p_page;
      s_op_start ##0 (op == 8'h02 || op == 8'h05) |-> ##[1:600] !stall;
   endproperty
   property p_mass;
      run_cnt < MASS_MAX;
   endproperty
   property p_quiet;
      stall |-> !wr && !rd;
   endproperty
   a_cmd_runs: assert property (p_cmd_runs) else $error("keyed command did not stall");
   a_no_key: assert property (p_no_key) else $error("command ran without key");
   a_bad_code: assert property (p_bad_code) else $error("unknown code ran");
   a_from_cmd: assert property (p_from_cmd) else $error("stall without command");
   a_short: assert property (p_short) else $error("short op too long");
   a_page: assert property (p_page) else $error("page op too long");
   a_mass: assert property (p_mass) else $error("stall too long");
   a_quiet: assert property (p_quiet) else $error("strobe during stall");
endmodule : fmc_properties
`default_nettype wire

// ### verif/testbench.sv
// testbench: drives the user side of the core end and checks flash results
// assumes: core end and controller joined by fmc_if, 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import fmc_pkg::*;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic user_wr = 1'b0;
   logic user_rd = 1'b0;
   logic [7:0] user_addr = 8'h00;
   logic [7:0] user_wdata = 8'h00;
   logic user_ack, user_busy, irq_taken, busy;
   logic [7:0] user_rdata, last_cmd, got;
   int fail_count = 0;
   int n_checks = 0;
   localparam logic [7:0] RA [10] = '{FMC_A_CMD, FMC_A_KEY, FMC_A_PKEY, FMC_A_DATA, FMC_A_WEG0,
      FMC_A_WEG1, FMC_A_RDG, FMC_A_PTRL, FMC_A_PTRH, 8'hc0};
   localparam logic [7:0] RV [10] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00,
      8'h00, 8'h00};
   fmc_if bus ();
   fmc_core_end fmc_core_end_i (.clock(clock), .nrst(nrst), .bus(bus), .user_wr(user_wr),
      .user_rd(user_rd), .user_addr(user_addr), .user_wdata(user_wdata), .user_ack(user_ack),
      .user_rdata(user_rdata), .user_busy(user_busy), .irq_taken(irq_taken));
   fmc_ctrl fmc_ctrl_i (.clock(clock), .nrst(nrst), .bus(bus), .busy(busy), .last_cmd(last_cmd));
   fmc_properties fmc_properties_i (.clock(clock), .nrst(nrst), .addr(bus.addr),
      .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .stall(bus.stall));
   always #5 clock = ~clock;
   // -------------------------------------------------
   // tasks
   // -------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic hold(input logic is_rd, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clock);
      user_addr <= a;
      user_wdata <= d;
      user_rd <= is_rd;
      user_wr <= !is_rd;
      do begin
         @(posedge clock);
         n++;
      end while (user_ack !== 1'b1 && n < 50);
      user_wr <= 1'b0;
      user_rd <= 1'b0;
      got = user_rdata;
      if (n >= 50) begin
         chk("ack wait", 8'h01, 8'h00);
         tally_and_finish();
      end
   endtask : hold
   task automatic settle();
      int n;
      n = 0;
      repeat (3) @(posedge clock);
      while (user_busy !== 1'b0 && n < 20000) begin
         @(posedge clock);
         n++;
      end
      if (n >= 20000) begin
         chk("busy wait", 8'h00, 8'h01);
         tally_and_finish();
      end
   endtask : settle
   task automatic cmd(input logic [7:0] code);
      hold(1'b0, FMC_A_KEY, FMC_ACCESS_KEY);
      hold(1'b0, FMC_A_CMD, code);
      settle();
   endtask : cmd
   task automatic point(input logic [13:0] a);
      hold(1'b0, FMC_A_PTRL, a[7:0]);
      hold(1'b0, FMC_A_PTRH, {2'b00, a[13:8]});
   endtask : point
   task automatic peek(input logic [13:0] a);
      point(a);
      cmd(8'h04);
      hold(1'b1, FMC_A_DATA, 8'h00);
   endtask : peek
   task automatic poke(input logic [13:0] a, input logic [7:0] d, input logic [7:0] code);
      point(a);
      hold(1'b0, FMC_A_DATA, d);
      cmd(code);
   endtask : poke
   task automatic guards(input logic [7:0] pk, input logic [7:0] w0, input logic [7:0] rg);
      hold(1'b0, FMC_A_PKEY, pk);
      hold(1'b0, FMC_A_WEG0, w0);
      hold(1'b0, FMC_A_RDG, rg);
      point(14'h3fff); // high pointer 0x3f guards pages 30 and 31
      cmd(8'h08);
   endtask : guards
   // -------------------------------------------------
   // main sequence
   // -------------------------------------------------
   initial begin
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         hold(1'b1, RA[i], 8'h00);
         chk("reset value", RV[i], got);
      end
      $display("test registers done");
      hold(1'b0, FMC_A_CMD, 8'h04);
      settle();
      chk("unkeyed command", 8'h00, last_cmd);
      cmd(8'h06);
      chk("unknown code", 8'h00, last_cmd);
      hold(1'b1, FMC_A_KEY, 8'h00);
      chk("key kept", FMC_ACCESS_KEY, got);
      $display("test refusals done");
      hold(1'b0, FMC_A_KEY, FMC_ACCESS_KEY);
      hold(1'b0, FMC_A_CMD, 8'h03);
      repeat (10) @(posedge clock);
      chk("irq held", 8'h00, {7'h00, irq_taken});
      chk("core held", 8'h01, {7'h00, busy});
      chk("busy seen", 8'h01, {7'h00, user_busy});
      settle();
      @(posedge clock);
      chk("irq free", 8'h01, {7'h00, irq_taken});
      chk("core free", 8'h00, {7'h00, busy});
      peek(14'h0123);
      chk("erased byte", FMC_ERASED, got);
      hold(1'b1, FMC_A_KEY, 8'h00);
      chk("key spent", 8'hff, got);
      $display("test mass erase done");
      poke(14'h0123, 8'h5a, 8'h01);
      poke(14'h0100, 8'h00, 8'h01);
      poke(14'h0200, 8'h3c, 8'h01);
      peek(14'h0123);
      chk("written byte", 8'h5a, got);
      poke(14'h0123, 8'h0f, 8'h01);
      peek(14'h0123);
      chk("bits only cleared", 8'h0a, got);
      poke(14'h0123, 8'ha5, 8'h05);
      peek(14'h0123);
      chk("erase and write", 8'ha5, got);
      peek(14'h0100);
      chk("page wiped", FMC_ERASED, got);
      point(14'h01ff);
      cmd(8'h02);
      peek(14'h0123);
      chk("page erase", FMC_ERASED, got);
      peek(14'h0200);
      chk("next page kept", 8'h3c, got);
      $display("test write and erase done");
      guards(8'h77, 8'hfe, 8'hfd);
      peek(FMC_PROT_KEY_ADDR);
      chk("stored key", 8'h77, got);
      peek(FMC_PROT_WE0_ADDR);
      chk("stored guard", 8'hfe, got);
      peek(FMC_PROT_RD_ADDR);
      chk("stored read guard", 8'hfd, got);
      poke(14'h0010, 8'h33, 8'h01);
      peek(14'h0010);
      chk("guarded write", FMC_ERASED, got);
      poke(14'h3e00, 8'h00, 8'h01);
      peek(14'h3e00);
      chk("last page kept", FMC_ERASED, got);
      hold(1'b0, FMC_A_DATA, 8'h11);
      point(14'h0800);
      cmd(8'h04);
      hold(1'b1, FMC_A_DATA, 8'h00);
      chk("guarded read", 8'h11, got);
      guards(8'h12, 8'h00, 8'hff);
      peek(FMC_PROT_WE0_ADDR);
      chk("wrong key guard", 8'hfe, got);
      peek(FMC_PROT_KEY_ADDR);
      chk("key once", 8'h77, got);
      guards(8'h77, 8'hfc, 8'hff);
      peek(FMC_PROT_WE0_ADDR);
      chk("right key guard", 8'hfc, got);
      $display("test protection done");
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
